// ===== design/pcr_pkg.sv
package pcr_pkg;

    // ------------------------------------------------------------
    // command codes and response status
    // ------------------------------------------------------------
    localparam logic [7:0]  PCR_CMD_SET   = 8'h60;   // set run-time settings
    localparam logic [7:0]  PCR_CMD_GET   = 8'h61;   // get run-time settings
    localparam logic [7:0]  PCR_ST_OK     = 8'h00;   // completed successfully
    localparam logic [7:0]  PCR_ST_BAD    = 8'h01;   // unknown command code

    // ------------------------------------------------------------
    // packet layout (byte n sits in word n/4, lane n%4)
    // ------------------------------------------------------------
    localparam int          PCR_PKT_WORDS = 16;      // 64-byte packet
    localparam int          PCR_ALTER_BIT = 31;      // byte 7 bit 7 in word 1
    localparam int          PCR_LVL_BIT   = 4;       // output level in a pin byte
    localparam int          PCR_DIR_BIT   = 3;       // 1 input, 0 output
    localparam logic [2:0]  PCR_FN_GPIO   = 3'h0;    // general-purpose i/o
    localparam logic [2:0]  PCR_FN_MAX_P1 = 3'h4;    // last legal code, pin one
    localparam logic [2:0]  PCR_FN_MAX_P2 = 3'h3;    // last legal code, pins two/three

    // ------------------------------------------------------------
    // reset values (power-up defaults, never rewritten)
    // ------------------------------------------------------------
    localparam logic [2:0]  PCR_RST_FN    = 3'h0;    // gpio
    localparam logic        PCR_RST_DIR   = 1'b1;    // input
    localparam logic        PCR_RST_LVL   = 1'b0;    // low

    // ------------------------------------------------------------
    // apb map (byte addresses)
    // ------------------------------------------------------------
    localparam int          PCR_AW        = 12;
    localparam logic [5:0]  PCR_PAGE_CMD  = 6'h00;   // 0x000-0x03c command packet
    localparam logic [5:0]  PCR_PAGE_RESP = 6'h02;   // 0x080-0x0bc response packet
    localparam logic [11:0] PCR_OFS_CTRL  = 12'h040; // bit0 go (write)
    localparam logic [11:0] PCR_OFS_STAT  = 12'h044; // bit0 done
    localparam logic [11:0] PCR_OFS_PINS  = 12'h048; // pin input levels

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        PCR_IDLE = 1'b0,
        PCR_EXEC = 1'b1
    } pcr_state_t;

endpackage

// ===== design/pcr_top.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// one pin: function, direction, level and pad drive
// ------------------------------------------------------------
module pcr_pin
    import pcr_pkg::*;
#(
    parameter logic [2:0] FN_MAX = 3'h3     // highest legal function code
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // settings update
    input  wire logic       apply,
    input  wire logic [7:0] sbyte,
    // state
    output logic      [2:0] func_r,
    output logic            dir_r,
    output logic            lvl_r,
    // pad
    output logic            pad_o_r,
    output logic            pad_oe_r
);
    wire       fn_ok    = (sbyte[2:0] <= FN_MAX);
    // bits 7-5 never looked at
    wire [2:0] func_nxt = (apply && fn_ok) ? sbyte[2:0] : func_r;
    wire       dir_nxt  = apply ? sbyte[PCR_DIR_BIT] : dir_r;
    wire       lvl_nxt  = apply ? sbyte[PCR_LVL_BIT] : lvl_r;
    // direction only counts in gpio mode; other functions own the pad
    wire       oe_nxt   = (func_nxt == PCR_FN_GPIO) && !dir_nxt;

    // state and pad flops, new values take effect on the next edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            func_r   <= PCR_RST_FN;
            dir_r    <= PCR_RST_DIR;
            lvl_r    <= PCR_RST_LVL;
            pad_o_r  <= PCR_RST_LVL;
            pad_oe_r <= 1'b0;
        end else begin
            func_r   <= func_nxt;
            dir_r    <= dir_nxt;
            lvl_r    <= lvl_nxt;
            pad_o_r  <= lvl_nxt;
            pad_oe_r <= oe_nxt;
        end
    end
endmodule

// ------------------------------------------------------------
// top: apb packet buffers, command sequencer, three pins
// ------------------------------------------------------------
module pcr_top
    import pcr_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pin one
    input  wire logic        pin_one_i,
    output logic             pin_one_o,
    output logic             pin_one_oe,
    output logic       [2:0] pin_one_func,
    // pin two
    input  wire logic        pin_two_i,
    output logic             pin_two_o,
    output logic             pin_two_oe,
    output logic       [2:0] pin_two_func,
    // pin three
    input  wire logic        pin_three_i,
    output logic             pin_three_o,
    output logic             pin_three_oe,
    output logic       [2:0] pin_three_func
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [31:0] cmd_mem [0:PCR_PKT_WORDS-1];   // command packet from software
    logic [31:0] resp_w0_r;                     // response bytes 0-3
    logic [31:0] resp_w2_r;                     // response bytes 8-11
    logic        done_r;                        // answer ready
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    pcr_state_t  state_r;
    pcr_state_t  state_nxt;
    logic  [2:0] fn1;
    logic  [2:0] fn2;
    logic  [2:0] fn3;
    logic        dir1;
    logic        dir2;
    logic        dir3;
    logic        lvl1;
    logic        lvl2;
    logic        lvl3;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // one wait state so that every answer comes from a flop
    wire       acc      = psel && penable && !pready_r;
    // completing edge: pready seen high, the only edge a write lands
    wire       fin      = psel && penable && pready_r;
    wire       aligned  = (paddr[1:0] == 2'b00);
    wire [3:0] widx     = paddr[5:2];
    wire       hit_cmd  = aligned && (paddr[11:6] == PCR_PAGE_CMD);
    wire       hit_resp = aligned && (paddr[11:6] == PCR_PAGE_RESP);
    wire       hit_ctrl = (paddr == PCR_OFS_CTRL);
    wire       hit_stat = (paddr == PCR_OFS_STAT);
    wire       hit_pins = (paddr == PCR_OFS_PINS);
    // response, status and pins are read only
    wire       bad_wr   = pwrite && !(hit_cmd || hit_ctrl);
    wire       bad_rd   = !pwrite && !(hit_cmd || hit_resp || hit_ctrl
                                       || hit_stat || hit_pins);
    wire       wr_cmd   = fin && pwrite && hit_cmd;
    wire       go       = fin && pwrite && hit_ctrl && pwdata[0];

    // read mux; unwritten response words read zero
    wire [31:0] resp_rd = (widx == 4'h0) ? resp_w0_r :
                          (widx == 4'h2) ? resp_w2_r : 32'h0000_0000;
    wire [31:0] rd_mux  = hit_cmd  ? cmd_mem[widx] :
                          hit_resp ? resp_rd :
                          hit_stat ? {31'h0000_0000, done_r} :
                          hit_pins ? {29'h0000_0000, pin_three_i, pin_two_i, pin_one_i} :
                          32'h0000_0000;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire       exec     = (state_r == PCR_EXEC);
    wire [7:0] code     = cmd_mem[0][7:0];
    wire       alter    = cmd_mem[1][PCR_ALTER_BIT];
    wire [7:0] b9       = cmd_mem[2][15:8];
    wire [7:0] b10      = cmd_mem[2][23:16];
    wire [7:0] b11      = cmd_mem[2][31:24];
    wire       is_set   = (code == PCR_CMD_SET);
    wire       is_get   = (code == PCR_CMD_GET);
    // only bytes 0, 7 and 9-11 matter; 12-63 are never decoded
    wire       apply    = exec && is_set && alter;
    wire [7:0] status   = (is_set || is_get) ? PCR_ST_OK : PCR_ST_BAD;
    // live settings byte per pin, bits 7-5 zero
    wire [7:0] live1    = {3'b000, lvl1, dir1, fn1};
    wire [7:0] live2    = {3'b000, lvl2, dir2, fn2};
    wire [7:0] live3    = {3'b000, lvl3, dir3, fn3};
    wire [31:0] w2_nxt  = is_get ? {live3, live2, live1, 8'h00} : 32'h0000_0000;

    // sequencer: go starts a one-cycle execute
    always_comb begin
        case (state_r)
            PCR_IDLE: state_nxt = go ? PCR_EXEC : PCR_IDLE;
            PCR_EXEC: state_nxt = PCR_IDLE;
            default:  state_nxt = PCR_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    // command buffer; no reset needed for data storage
    always_ff @(posedge pclk) begin
        if (wr_cmd) begin
            cmd_mem[widx] <= pwdata;
        end
    end

    // apb answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= acc;
            pslverr_r <= acc && (bad_wr || bad_rd || !aligned);
            prdata_r  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // response builder; get reports the settings before this edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= PCR_IDLE;
            done_r    <= 1'b0;
            resp_w0_r <= 32'h0000_0000;
            resp_w2_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            if (exec) begin
                resp_w0_r <= {16'h0000, status, code};
                resp_w2_r <= w2_nxt;
                done_r    <= 1'b1;
            end else if (go) begin
                done_r    <= 1'b0;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    pcr_pin #(.FN_MAX(PCR_FN_MAX_P1)) u_pin_one (
        .clk(pclk), .rst_n(presetn), .apply(apply), .sbyte(b9),
        .func_r(fn1), .dir_r(dir1), .lvl_r(lvl1),
        .pad_o_r(pin_one_o), .pad_oe_r(pin_one_oe)
    );
    pcr_pin #(.FN_MAX(PCR_FN_MAX_P2)) u_pin_two (
        .clk(pclk), .rst_n(presetn), .apply(apply), .sbyte(b10),
        .func_r(fn2), .dir_r(dir2), .lvl_r(lvl2),
        .pad_o_r(pin_two_o), .pad_oe_r(pin_two_oe)
    );
    pcr_pin #(.FN_MAX(PCR_FN_MAX_P2)) u_pin_three (
        .clk(pclk), .rst_n(presetn), .apply(apply), .sbyte(b11),
        .func_r(fn3), .dir_r(dir3), .lvl_r(lvl3),
        .pad_o_r(pin_three_o), .pad_oe_r(pin_three_oe)
    );

    assign pin_one_func   = fn1;
    assign pin_two_func   = fn2;
    assign pin_three_func = fn3;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pin_one_func: assert property (
        apply && (b9[2:0] <= PCR_FN_MAX_P1) |=> fn1 == $past(b9[2:0]))
        else $error("pin one function not loaded");
    a_pin_one_keep: assert property (
        apply && (b9[2:0] > PCR_FN_MAX_P1) |=> $stable(fn1))
        else $error("pin one took an illegal function");
    a_pin_two_func: assert property (
        apply |=> fn2 == (($past(b10[2:0]) <= PCR_FN_MAX_P2) ? $past(b10[2:0]) : $past(fn2)))
        else $error("pin two function wrong");
    a_pin_three_func: assert property (
        apply |=> fn3 == (($past(b11[2:0]) <= PCR_FN_MAX_P2) ? $past(b11[2:0]) : $past(fn3)))
        else $error("pin three function wrong");
    a_dir_gates_drive: assert property (
        pin_one_oe |-> (fn1 == PCR_FN_GPIO) && !dir1)
        else $error("pin one driven outside gpio output");
    a_out_level_driven: assert property (
        apply && (b10[2:0] == PCR_FN_GPIO) && !b10[PCR_DIR_BIT]
        |=> pin_two_oe && (pin_two_o == $past(b10[PCR_LVL_BIT])))
        else $error("pin two level not driven");
    a_set_resp_echo: assert property (
        exec && is_set |=> resp_w0_r[15:0] == {PCR_ST_OK, PCR_CMD_SET} && done_r)
        else $error("set answer wrong");
    a_get_resp_live: assert property (
        exec && is_get |=> resp_w0_r[15:0] == {PCR_ST_OK, PCR_CMD_GET}
        && resp_w2_r[15:8] == {3'b000, lvl1, dir1, fn1})
        else $error("get answer wrong");
    a_no_alter_keep: assert property (
        exec && !alter |=> $stable(fn1) && $stable(fn2) && $stable(fn3) && $stable(lvl1))
        else $error("pins changed without alter bit");
    a_go_to_done: assert property (
        go |=> !done_r ##1 done_r)
        else $error("command not completed in two cycles");

    c_set_cmd: cover property (apply);
    c_get_cmd: cover property (exec && is_get);
    c_bad_access: cover property (pslverr_r);
    c_drive_pin: cover property (!pin_one_oe ##1 pin_one_oe);
endmodule

`default_nettype wire

// ===== tb/pcr_host.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// host model: apb master sending fixed-length packets
// ------------------------------------------------------------
module pcr_host
    import pcr_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic err_r;  // error flag of the last transfer

    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        err_r = 1'b0;
    end

    // one transfer; request held until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the bench watchdog ends a dead slave
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // whole command: packet, go, poll done, fetch answer words 0 and 2
    task automatic cmd(input logic [31:0] w0, w1, w2, fill, output logic [31:0] r0, r2);
        logic [31:0] q;
        int i;
        // the packet is always sent whole, so reserved bytes are defined
        for (i = 0; i < PCR_PKT_WORDS; i++) begin
            xfer(1'b1, 12'(i * 4), (i == 0) ? w0 : (i == 1) ? w1 : (i == 2) ? w2 : fill, q);
        end
        xfer(1'b1, PCR_OFS_CTRL, 32'h0000_0001, q);
        q = 32'h0000_0000;
        // poll until done; a stale answer must never be fetched
        while (q[0] !== 1'b1) begin
            xfer(1'b0, PCR_OFS_STAT, 32'h0000_0000, q);
        end
        xfer(1'b0, 12'h080, 32'h0000_0000, r0);
        xfer(1'b0, 12'h088, 32'h0000_0000, r2);
    endtask
endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// bench top: host model, pads, scenarios, verdict
// ------------------------------------------------------------
module testbench
    import pcr_pkg::*;
;
    logic        pclk, presetn;             // clock and async reset
    logic        psel, penable, pwrite;     // apb control
    logic [11:0] paddr;                     // apb address
    logic [31:0] pwdata, prdata;            // apb data
    logic        pready, pslverr;           // apb answer
    logic        p1_o, p2_o, p3_o;          // pad output levels
    logic        p1_oe, p2_oe, p3_oe;       // pad drive enables
    logic [2:0]  f1, f2, f3;                // current function codes
    logic [2:0]  ext_r;                     // far-side pad drive
    logic [31:0] r0, r2;                    // answer words
    int          err_total, checked;        // verdict counters
    wire  [11:0] pins_w = {f1, f2, f3, p1_oe, p2_oe, p3_oe};
    // pad level: block drive wins when enabled
    wire         p1_i = p1_oe ? p1_o : ext_r[0];
    wire         p2_i = p2_oe ? p2_o : ext_r[1];
    wire         p3_i = p3_oe ? p3_o : ext_r[2];

    pcr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_one_i(p1_i), .pin_one_o(p1_o), .pin_one_oe(p1_oe),
        .pin_one_func(f1), .pin_two_i(p2_i), .pin_two_o(p2_o), .pin_two_oe(p2_oe),
        .pin_two_func(f2), .pin_three_i(p3_i), .pin_three_o(p3_o), .pin_three_oe(p3_oe),
        .pin_three_func(f3));
    pcr_host host_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // 250 mhz clock
    always #2 pclk = ~pclk;

    // ------------------------------------------------------------
    // comparison, verdict and helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // set command; bytes 12-63 filled with junk that must not matter
    task automatic set_cmd(input logic alt, input logic [7:0] b9, b10, b11);
        host_u.cmd({24'h0, PCR_CMD_SET}, {alt, 31'h0}, {b11, b10, b9, 8'h00},
                   32'ha5a5_a5a5, r0, r2);
        chk(r0, {16'h0, PCR_ST_OK, PCR_CMD_SET});
    endtask

    // get command with a zeroed body; answer word 2 holds the pin bytes
    task automatic get_chk(input logic [31:0] e2);
        host_u.cmd({24'h0, PCR_CMD_GET}, 32'h0, 32'h0, 32'h0, r0, r2);
        chk(r0, {16'h0, PCR_ST_OK, PCR_CMD_GET});
        chk(r2, e2);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_funcs();
        int i;
        // every legal code, with don't-care bits 7-5 set
        for (i = 0; i < 5; i++) begin
            set_cmd(1'b1, 8'he8 | 8'(i), 8'he8 | 8'(i % 4), 8'he8 | 8'((i + 1) % 4));
            chk({20'h0, pins_w},
                {20'h0, 3'(i), 3'(i % 4), 3'((i + 1) % 4), 3'b000});
        end
        get_chk(32'h0908_0c00);
    endtask

    task automatic t_illegal();
        // out-of-range codes leave the functions alone
        set_cmd(1'b1, 8'h0d, 8'h0c, 8'h0f);
        chk({20'h0, pins_w}, {20'h0, 3'd4, 3'd0, 3'd1, 3'b000});
    endtask

    task automatic t_gpio_out();
        // pin one drives high, pin two drives low, pin three stays input
        set_cmd(1'b1, 8'h10, 8'h00, 8'h18);
        chk({29'h0, p1_oe, p2_oe, p3_oe}, 32'h6);
        chk({30'h0, p1_o, p2_o}, 32'h2);
        get_chk(32'h1800_1000);
        host_u.xfer(1'b0, PCR_OFS_PINS, 32'h0, r0);
        chk(r0, 32'h5);
    endtask

    task automatic t_dir_alt();
        // direction bit is inert under an alternate function
        set_cmd(1'b1, 8'h01, 8'h11, 8'h00);
        chk({20'h0, pins_w}, {20'h0, 3'd1, 3'd1, 3'd0, 3'b001});
        // alter bit clear: nothing moves
        set_cmd(1'b0, 8'h03, 8'h03, 8'h13);
        chk({20'h0, pins_w}, {20'h0, 3'd1, 3'd1, 3'd0, 3'b001});
        chk({31'h0, p3_o}, 32'h0);
    endtask

    task automatic t_refuse();
        // unmapped read and a write to the answer page are refused
        host_u.xfer(1'b0, 12'h0fc, 32'h0, r0);
        chk({31'h0, host_u.err_r}, 32'h1);
        host_u.xfer(1'b1, 12'h080, 32'hffff_ffff, r0);
        chk({31'h0, host_u.err_r}, 32'h1);
        // unknown code: echoed with the bad status, pins untouched
        host_u.cmd(32'h0000_0062, {1'b1, 31'h0}, 32'h0303_0300, 32'h0, r0, r2);
        chk(r0, {16'h0, PCR_ST_BAD, 8'h62});
        chk({20'h0, pins_w}, {20'h0, 3'd1, 3'd1, 3'd0, 3'b001});
        // pin one fn 1, pin two fn 1 level 1, pin three gpio output low
        get_chk(32'h0011_0100);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ext_r = 3'b100;
        err_total = 0;
        checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk({20'h0, pins_w}, 32'h0);
        get_chk(32'h0808_0800);
        t_funcs();
        t_illegal();
        t_gpio_out();
        t_dir_alt();
        t_refuse();
        // mid-run reset: run-time settings go, power-up defaults return
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk({20'h0, pins_w}, 32'h0);
        get_chk(32'h0808_0800);
        results();
    end

    // about 1200 cycles expected; a hang ends the run here
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        results();
    end
endmodule

`default_nettype wire
